// *** src/wba_map.svh ***
/*
 alu map: field positions, operation codes, reset values and operand limits for the word/byte alu.
 assumes: included by its bare name from the package and the alu modules.
*/
`ifndef WBA_MAP_SVH
`define WBA_MAP_SVH

// processor status field positions
`define WBA_PS_C 0
`define WBA_PS_V 1
`define WBA_PS_Z 2
`define WBA_PS_N 3
`define WBA_PS_TRACE 4
`define WBA_PS_PRIO_LO 5
`define WBA_PS_PRIO_HI 7

// instruction fields
`define WBA_BYTE_BIT 15
`define WBA_XREG_LO 6
`define WBA_XREG_HI 8

// reset values
`define WBA_PS_RESET 8'h00

// operation codes
`define WBA_OP_COPY 4'h0
`define WBA_OP_ADD 4'h1
`define WBA_OP_SUB 4'h2
`define WBA_OP_TEST 4'h3
`define WBA_OP_CLRM 4'h4
`define WBA_OP_SETM 4'h5
`define WBA_OP_XOR 4'h6
`define WBA_OP_CACC 4'h7
`define WBA_OP_BDED 4'h8
`define WBA_OP_SFILL 4'h9
`define WBA_OP_SLOAD 4'hA

// operand limits for carry-accumulate
`define WBA_WORD_MAXPOS 16'h7FFF
`define WBA_WORD_ALL1 16'hFFFF
`define WBA_BYTE_MAXPOS 8'h7F
`define WBA_BYTE_ALL1 8'hFF

`endif

// *** src/wba_pkg.sv ***
/*
 package: carrier types of the word/byte alu.
 assumes: wba_map.svh is on the include path.
*/
`include "wba_map.svh"

package wba_pkg;

   typedef struct packed {
      logic n;
      logic z;
      logic v;
      logic c;
   } wba_flags_t;

   typedef struct packed {
      logic valid;
      logic [15:0] instr;
      logic [3:0] op;
      logic [15:0] src;
      logic [15:0] dst;
      logic [15:0] xreg;
      logic dstIsReg;
   } wba_req_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] data;
      logic byteMode;
   } wba_res_t;

   typedef enum logic [2:0] {
      WBA_IDLE = 3'b001,
      WBA_READ = 3'b010,
      WBA_WRITE = 3'b100
   } wba_state_t;

   typedef struct packed {
      logic [7:0] ps;
      wba_state_t st;
      wba_req_t req;
      wba_res_t res;
      logic readReq;
      logic [2:0] xSel;
      logic ready;
      logic [31:0] prdata;
      logic pready;
      logic [3:0] opCtl;
   } wba_core_t;

endpackage

// *** src/wba_calc.sv ***
/*
 wba_calc: combinational result and flag generation for one operation, word or byte.
 assumes: operands and current flags valid in the same cycle; no state.
*/
`timescale 1ns/1ps
`include "wba_map.svh"

module wba_calc (
   // operation
   input wire logic [3:0] op,
   input wire logic byteMode,
   // operands
   input wire logic [15:0] src,
   input wire logic [15:0] dst,
   input wire logic [15:0] xreg,
   input wire logic dstIsReg,
   input wire wba_pkg::wba_flags_t flagsIn,
   input wire logic [7:0] psIn,
   // results
   output wba_pkg::wba_flags_t flagsOut,
   output logic [15:0] result,
   output logic writeBack,
   output logic [7:0] psOut
);
   logic [16:0] sum;
   logic [15:0] r;
   logic sgn;
   logic zer;
   logic msbS;
   logic msbD;
   logic msbR;

   always_comb begin
      sum = 17'h0;
      r = 16'h0000;
      writeBack = 1'b1;
      psOut = psIn;
      flagsOut = flagsIn;
      case (op)
         `WBA_OP_COPY: begin
            r = src;
            if (byteMode && dstIsReg) begin
               r = {{8{src[7]}}, src[7:0]};
            end
         end
         `WBA_OP_ADD: begin
            sum = {1'b0, dst} + {1'b0, src};
            r = sum[15:0];
         end
         `WBA_OP_SUB: begin
            sum = {1'b0, dst} - {1'b0, src};
            r = sum[15:0];
         end
         `WBA_OP_TEST: begin
            r = src & dst;
            writeBack = 1'b0;
         end
         `WBA_OP_CLRM: r = dst & ~src;
         `WBA_OP_SETM: r = dst | src;
         `WBA_OP_XOR: r = dst ^ xreg;
         `WBA_OP_CACC: begin
            sum = {1'b0, dst} + {16'h0000, flagsIn.c};
            r = sum[15:0];
         end
         `WBA_OP_BDED: begin
            sum = {1'b0, dst} - {16'h0000, flagsIn.c};
            r = sum[15:0];
         end
         `WBA_OP_SFILL: r = flagsIn.n ? 16'hFFFF : 16'h0000;
         `WBA_OP_SLOAD: begin
            writeBack = 1'b0;
            psOut = src[7:0];
            psOut[`WBA_PS_TRACE] = psIn[`WBA_PS_TRACE];
         end
         default: writeBack = 1'b0;
      endcase
      // add/sub have no byte form
      if (byteMode && op != `WBA_OP_ADD && op != `WBA_OP_SUB && op != `WBA_OP_COPY) begin
         r = {dst[15:8], r[7:0]};
      end
      result = r;
      if (byteMode && op != `WBA_OP_ADD && op != `WBA_OP_SUB) begin
         sgn = r[7];
         zer = (r[7:0] == 8'h00);
         msbS = src[7];
         msbD = dst[7];
         msbR = r[7];
      end else begin
         sgn = r[15];
         zer = (r == 16'h0000);
         msbS = src[15];
         msbD = dst[15];
         msbR = r[15];
      end
      case (op)
         `WBA_OP_COPY, `WBA_OP_TEST, `WBA_OP_CLRM, `WBA_OP_SETM, `WBA_OP_XOR: begin
            flagsOut.n = sgn;
            flagsOut.z = zer;
            flagsOut.v = 1'b0;
         end
         `WBA_OP_ADD: begin
            flagsOut.n = sgn;
            flagsOut.z = zer;
            flagsOut.v = (msbS == msbD) && (msbR != msbD);
            flagsOut.c = sum[16];
         end
         `WBA_OP_SUB: begin
            flagsOut.n = sgn;
            flagsOut.z = zer;
            flagsOut.v = (msbS != msbD) && (msbR == msbS);
            flagsOut.c = sum[16];
         end
         `WBA_OP_CACC: begin
            flagsOut.n = sgn;
            flagsOut.z = zer;
            if (byteMode) begin
               flagsOut.v = flagsIn.c && dst[7:0] == `WBA_BYTE_MAXPOS;
               flagsOut.c = flagsIn.c && dst[7:0] == `WBA_BYTE_ALL1;
            end else begin
               flagsOut.v = flagsIn.c && dst == `WBA_WORD_MAXPOS;
               flagsOut.c = flagsIn.c && dst == `WBA_WORD_ALL1;
            end
         end
         `WBA_OP_BDED: begin
            flagsOut.n = sgn;
            flagsOut.z = zer;
            if (byteMode) begin
               flagsOut.v = dst[7:0] == 8'h80;
               flagsOut.c = flagsIn.c && dst[7:0] == 8'h00;
            end else begin
               flagsOut.v = dst == 16'h8000;
               flagsOut.c = flagsIn.c && dst == 16'h0000;
            end
         end
         `WBA_OP_SFILL: begin
            flagsOut.z = ~flagsIn.n;
            flagsOut.v = 1'b0;
         end
         `WBA_OP_SLOAD: begin
            flagsOut = src[3:0];
         end
         default: flagsOut = flagsIn;
      endcase
   end
endmodule

// *** src/wba_alu.sv ***
/*
 wba_alu: word/byte alu with flags and processor status, with an apb port for status and control.
 assumes: decoder presents one request, waits for rdDst pulse then supplies dst; single clock.
*/
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "wba_map.svh"


module wba_alu (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // operation request
   input wire logic reqValid,
   input wire logic [15:0] reqInstr,
   input wire logic [3:0] reqOp,
   input wire logic [15:0] reqSrc,
   input wire logic dstIsReg,
   // destination read and register file
   output logic rdDst,
   input wire logic [15:0] rdData,
   output logic [2:0] xregSel,
   input wire logic [15:0] xregData,
   // result
   output logic reqReady,
   output logic resValid,
   output logic resWrite,
   output logic resByte,
   output logic [15:0] resData,
   output logic [7:0] psOut,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   localparam logic [11:0] ADDR_PS = 12'h000;
   localparam logic [11:0] ADDR_CTL = 12'h004;

   logic rstQ1;
   logic rstQ2;
   wba_pkg::wba_core_t q;
   wba_pkg::wba_core_t next_q;
   wba_pkg::wba_flags_t calcFlags;
   logic [15:0] calcRes;
   logic calcWb;
   logic [7:0] calcPs;
   logic byteSel;
   logic slverr;
   logic next_slverr;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstQ1 <= 1'b0;
         rstQ2 <= 1'b0;
      end else begin
         rstQ1 <= 1'b1;
         rstQ2 <= rstQ1;
      end
   end

   assign byteSel = q.req.instr[`WBA_BYTE_BIT] && q.req.op != `WBA_OP_ADD && q.req.op != `WBA_OP_SUB
      && q.req.op != `WBA_OP_SLOAD && q.req.op != `WBA_OP_XOR;

   wba_calc u_calc (
      .op(q.req.op),
      .byteMode(byteSel),
      .src(q.req.src),
      .dst(q.req.dst),
      .xreg(q.req.xreg),
      .dstIsReg(q.req.dstIsReg),
      .flagsIn(q.ps[3:0]),
      .psIn(q.ps),
      .flagsOut(calcFlags),
      .result(calcRes),
      .writeBack(calcWb),
      .psOut(calcPs)
   );

   always_comb begin
      next_q = q;
      next_slverr = 1'b0;
      next_q.res.valid = 1'b0;
      next_q.readReq = 1'b0;
      next_q.pready = 1'b0;
      case (q.st)
         wba_pkg::WBA_IDLE: begin
            if (reqValid && q.ready) begin
               next_q.req.valid = 1'b1;
               next_q.req.instr = reqInstr;
               next_q.req.op = reqOp;
               next_q.req.src = reqSrc;
               next_q.req.dstIsReg = dstIsReg;
               next_q.xSel = reqInstr[`WBA_XREG_HI:`WBA_XREG_LO];
               next_q.ready = 1'b0;
               if (reqOp == `WBA_OP_SLOAD) begin
                  next_q.st = wba_pkg::WBA_WRITE;
               end else begin
                  next_q.readReq = 1'b1;
                  next_q.st = wba_pkg::WBA_READ;
               end
            end
         end
         wba_pkg::WBA_READ: begin
            next_q.req.dst = rdData;
            next_q.req.xreg = xregData;
            next_q.st = wba_pkg::WBA_WRITE;
         end
         wba_pkg::WBA_WRITE: begin
            next_q.ps = {calcPs[7:4], calcFlags};
            if (q.req.op != `WBA_OP_SLOAD) begin
               next_q.ps[7:4] = q.ps[7:4];
            end
            next_q.res.valid = 1'b1;
            next_q.res.write = calcWb && q.opCtl[0] == 1'b0;
            next_q.res.data = calcRes;
            next_q.res.byteMode = byteSel && !(q.req.op == `WBA_OP_COPY && q.req.dstIsReg);
            next_q.req.valid = 1'b0;
            next_q.ready = 1'b1;
            next_q.st = wba_pkg::WBA_IDLE;
         end
         default: begin
            next_q.st = wba_pkg::WBA_IDLE;
            next_q.ready = 1'b1;
         end
      endcase
      if (psel && !penable) begin
         next_q.pready = 1'b1;
         case (paddr)
            ADDR_PS: next_q.prdata = {24'h000000, q.ps};
            ADDR_CTL: next_q.prdata = {25'h0, q.st, q.opCtl};
            default: begin
               next_q.prdata = 32'h00000000;
               next_slverr = 1'b1;
            end
         endcase
      end
      if (psel && penable && q.pready && pwrite) begin
         if (paddr == ADDR_PS && q.st == wba_pkg::WBA_IDLE) begin
            next_q.ps = pwdata[7:0];
         end
         if (paddr == ADDR_CTL) begin
            next_q.opCtl = pwdata[3:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rstQ2) begin
      if (!rstQ2) begin
         q <= '0;
         q.ps <= `WBA_PS_RESET;
         q.st <= wba_pkg::WBA_IDLE;
         q.ready <= 1'b1;
         slverr <= 1'b0;
      end else begin
         q <= next_q;
         slverr <= next_slverr;
      end
   end

   always_comb begin
      rdDst = q.readReq;
      xregSel = q.xSel;
      reqReady = q.ready;
      resValid = q.res.valid;
      resWrite = q.res.write;
      resByte = q.res.byteMode;
      resData = q.res.data;
      psOut = q.ps;
      prdata = q.prdata;
      pready = q.pready;
      pslverr = slverr;
   end
endmodule

// *** verification/wba_alu_monitor.sv ***
/*
 wba_alu_monitor: timing and flag checks on the alu ports.
 assumes: one clock; rst_n low disables every check.
*/
`timescale 1ns/1ps
`include "wba_map.svh"
module wba_alu_monitor (
   // clock and reset
   input logic clk,
   input logic rst_n,
   // request
   input logic reqValid,
   input logic reqReady,
   input logic [3:0] reqOp,
   input logic [15:0] reqInstr,
   input logic [15:0] reqSrc,
   // answer
   input logic rdDst,
   input logic [2:0] xregSel,
   input logic resValid,
   input logic resWrite,
   input logic [15:0] resData,
   input logic [7:0] psOut
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence sTake;
      reqValid && reqReady && reqOp != `WBA_OP_SLOAD;
   endsequence
   sequence sRead;
      rdDst ##1 !rdDst;
   endsequence
   sequence sLoad;
      reqValid && reqReady && reqOp == `WBA_OP_SLOAD;
   endsequence
   sequence sFill;
      reqValid && reqReady && reqOp == `WBA_OP_SFILL;
   endsequence
   sequence sLogic;
      reqValid && reqReady && reqOp inside {`WBA_OP_COPY, `WBA_OP_TEST, `WBA_OP_CLRM, `WBA_OP_SETM, `WBA_OP_XOR};
   endsequence
   chk_read_first: assert property (sTake |=> sRead)
      else $error("no single read strobe");
   chk_write_read: assert property (resValid && resWrite |-> $past(rdDst, 2))
      else $error("write without read");
   chk_load_value: assert property (
      sLoad |-> ##2 resValid && psOut[3:0] == $past(reqSrc[3:0], 2) && psOut[7:5] == $past(reqSrc[7:5], 2))
      else $error("status load value");
   chk_trace_block: assert property (
      sLoad |-> ##2 (!psOut[`WBA_PS_TRACE] || $past(psOut[`WBA_PS_TRACE], 2)))
      else $error("trace set by load");
   chk_fill_data: assert property (sFill ##0 !reqInstr[15] |-> ##3 resData == {16{$past(psOut[3], 3)}})
      else $error("fill data");
   chk_fill_flags: assert property (
      sFill |-> ##3 psOut[3:0] == {$past(psOut[3], 3), !$past(psOut[3], 3), 1'b0, $past(psOut[0], 3)})
      else $error("fill flags");
   chk_logic_vclr: assert property (sLogic |-> ##3 !psOut[`WBA_PS_V])
      else $error("overflow not cleared");
   chk_xor_select: assert property (
      reqValid && reqReady && reqOp == `WBA_OP_XOR |-> ##2 xregSel == $past(reqInstr[8:6], 2))
      else $error("xor register select");
endmodule
bind wba_alu wba_alu_monitor u_mon (.clk, .rst_n, .reqValid, .reqReady, .reqOp, .reqInstr, .reqSrc,
   .rdDst, .xregSel, .resValid, .resWrite, .resData, .psOut);

// *** verification/wba_dec_model.sv ***
/*
 wba_dec_model: decoder side, answers destination and register reads.
 assumes: dstVal set by the bench; register k holds 16'h1111 times k.
*/
`timescale 1ns/1ps
module wba_dec_model (
   // clock and reset
   input logic clk,
   input logic rst_n,
   // alu side
   input logic rdDst,
   input logic [2:0] xregSel,
   input logic [15:0] dstVal,
   output logic [15:0] rdData,
   output logic [15:0] xregData
);
   logic held;
   logic [15:0] regVal;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         held <= 1'b0;
      else
         held <= rdDst;
   end
   // valid only around the read strobe, inverted otherwise
   assign regVal = 16'h1111 * {13'h0, xregSel};
   assign rdData = (rdDst || held) ? dstVal : ~dstVal;
   assign xregData = (rdDst || held) ? regVal : ~regVal;
endmodule

// *** verification/tb_top.sv ***
/*
 tb_top: table of alu cases, then apb, reset and carry chain cases.
 assumes: wba_dec_model answers reads; the monitor is bound in.
*/
`timescale 1ns/1ps
`include "wba_map.svh"
module tb_top;
   typedef struct packed {
      logic [3:0] op;
      logic [15:0] ins;
      logic isReg;
      logic [15:0] src;
      logic [15:0] dst;
      logic [7:0] ps;
      logic [15:0] res;
      logic wr;
      logic [7:0] psE;
   } wba_row_t;
   localparam wba_row_t ROWS [15] = '{
      '{4'h7,16'h0000,1'b0,16'h0000,16'h7FFF,8'h01,16'h8000,1'b1,8'h0A},
      '{4'h7,16'h8000,1'b0,16'h0000,16'h12FF,8'h01,16'h1200,1'b1,8'h05},
      '{4'h8,16'h0000,1'b0,16'h0000,16'h0000,8'h01,16'hFFFF,1'b1,8'h09},
      '{4'h8,16'h8000,1'b0,16'h0000,16'h1200,8'h01,16'h12FF,1'b1,8'h09},
      '{4'h9,16'h0000,1'b0,16'h0000,16'h1234,8'h0B,16'hFFFF,1'b1,8'h09},
      '{4'h0,16'h0000,1'b0,16'h8000,16'h1234,8'h03,16'h8000,1'b1,8'h09},
      '{4'h0,16'h8000,1'b1,16'h0080,16'h1234,8'h00,16'hFF80,1'b1,8'h08},
      '{4'h2,16'h0000,1'b0,16'h0001,16'h0000,8'h00,16'hFFFF,1'b1,8'h09},
      '{4'h3,16'h0000,1'b0,16'h00F0,16'h0F00,8'h03,16'h0000,1'b0,8'h05},
      '{4'h4,16'h0000,1'b0,16'h029C,16'h0249,8'h0F,16'h0041,1'b1,8'h01},
      '{4'h5,16'h0000,1'b0,16'h029C,16'h0249,8'h00,16'h02DD,1'b1,8'h00},
      '{4'h6,16'h78C0,1'b0,16'h0000,16'h0249,8'h01,16'h317A,1'b1,8'h01},
      '{4'hA,16'h0000,1'b0,16'h00FF,16'h0000,8'h00,16'h0000,1'b0,8'hEF},
      '{4'h1,16'h0000,1'b0,16'hFFFF,16'hFFFF,8'h00,16'hFFFE,1'b1,8'h09},
      '{4'h7,16'h0000,1'b0,16'h0000,16'hFFFF,8'h00,16'h0000,1'b1,8'h05}
   };
   logic clk = 1'b0, rst_n = 1'b0, reqValid = 1'b0, dstIsReg = 1'b0;
   logic [15:0] reqInstr = 16'h0000, reqSrc = 16'h0000, dstVal = 16'h0000;
   logic [3:0] reqOp = 4'h0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, gotRd;
   logic rdDst, reqReady, resValid, resWrite, resByte, pready, pslverr, gotWr, gotErr, gotByte;
   logic [15:0] rdData, xregData, resData, gotData;
   logic [2:0] xregSel;
   logic [7:0] psOut, gotPs;
   int fails = 0;
   int checked = 0;
   always #4 clk = ~clk;
   wba_alu u_dut (.clk, .rst_n, .reqValid, .reqInstr, .reqOp, .reqSrc, .dstIsReg, .rdDst, .rdData,
      .xregSel, .xregData, .reqReady, .resValid, .resWrite, .resByte, .resData, .psOut,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   wba_dec_model u_model (.clk, .rst_n, .rdDst, .xregSel, .dstVal, .rdData, .xregData);
   task chk(input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("BAD %0t exp %h got %h", $time, e, g);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      gotRd = prdata;
      gotErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task run(input wba_row_t r);
      @(posedge clk);
      reqValid <= 1'b1;
      reqOp <= r.op;
      reqInstr <= r.ins;
      reqSrc <= r.src;
      dstIsReg <= r.isReg;
      dstVal <= r.dst;
      do @(posedge clk); while (reqReady !== 1'b1);
      reqValid <= 1'b0;
      do @(posedge clk); while (resValid !== 1'b1);
      gotData = resData;
      gotWr = resWrite;
      gotByte = resByte;
      gotPs = psOut;
   endtask
   task summarize();
      $display("fails %0d checked %0d", fails, checked);
      if (fails == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      fails++;
      summarize();
   end
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      chk(32'h0, 32'(psOut));
      chk(32'h1, 32'(reqReady));
      for (int i = 0; i < 13; i++) begin
         apb(1'b1, 12'h000, 32'(ROWS[i].ps));
         run(ROWS[i]);
         chk(32'(ROWS[i].psE), 32'(gotPs));
         if (ROWS[i].op != `WBA_OP_SLOAD)
            chk(32'(ROWS[i].wr), 32'(gotWr));
         if (ROWS[i].wr)
            chk(32'(ROWS[i].res), 32'(gotData));
         if (ROWS[i].wr)
            chk(32'(ROWS[i].ins[15] && !ROWS[i].isReg), 32'(gotByte));
      end
      apb(1'b0, 12'h000, 32'h0);
      chk(32'hEF, gotRd);
      apb(1'b0, 12'hFF0, 32'h0);
      chk(32'h0, gotRd);
      chk(32'h1, 32'(gotErr));
      apb(1'b1, 12'h004, 32'h1);
      run(ROWS[5]);
      chk(32'h0, 32'(gotWr));
      apb(1'b0, 12'h004, 32'h0);
      chk(32'h11, gotRd);
      apb(1'b1, 12'h004, 32'h0);
      rst_n <= 1'b0;
      @(negedge clk);
      chk(32'h0, 32'(psOut));
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      run(ROWS[13]);
      chk(32'(ROWS[13].res), 32'(gotData));
      chk(32'(ROWS[13].psE), 32'(gotPs));
      run(ROWS[14]);
      chk(32'(ROWS[14].res), 32'(gotData));
      chk(32'(ROWS[14].psE), 32'(gotPs));
      summarize();
   end
endmodule
